/* logic/bldr_defs.svh */
`ifndef BLDR_DEFS_SVH
`define BLDR_DEFS_SVH
// Functional notes
// - Boot select 0xB loads the stream from one-time memory, by default pages 0x40 to 0xDF.
// - The one-time-memory start page is programmable, letting the stream grow to 3072 bytes.
// - Boot select 0xE sets the host port to 16-bit acknowledge handshaking, little endian.
// - Boot select 0xF sets the host port to 8-bit interrupt handshaking, little endian.
// - In 8-bit host boot the device pulses acknowledge each time sixteen 32-bit words may go.
// - A host interrupt command makes the device call code at 0xFFA00000.
// - Boot selects 0xB, 0xE and 0xF first read a 16-byte header with byte count and destination.
// - Any number of blocks load, then execution starts at the reset vector register.
// - Pre-boot reads one-time memory, whose settings can customize or disable modes.
// - The wait line marks the end of pre-boot, and never toggles in NAND boot.
// - One-time settings can make pre-boot set up PLL, regulator, DDR and async memory.
// - A wakeup from hibernate takes a faster boot path than a hardware reset.
// - On software reset, reset-config bits 6 to 4 skip pre-boot or loader, or fake a wakeup.

// ----------------------------------------
// Boot select codes
// ----------------------------------------
`define BLDR_SEL_NAND 4'hD
`define BLDR_SEL_OTP 4'hB
`define BLDR_SEL_HOST16 4'hE
`define BLDR_SEL_HOST8 4'hF
// ----------------------------------------
// One-time memory layout
// ----------------------------------------
`define BLDR_OTP_START_DEF 8'h40
`define BLDR_OTP_LAST_PAGE 8'hDF
`define BLDR_OTP_MAX_BYTES 12'hC00
`define BLDR_OTP_PAGE_BYTES 12'h010
`define BLDR_OTP_CFG_ADDR 8'h00
`define BLDR_PAGE_LAST_WORD 2'h3
// Config word bits
`define BLDR_CFG_OTP_DIS 0
`define BLDR_CFG_HOST_DIS 1
`define BLDR_CFG_PLL 2
`define BLDR_CFG_VREG 3
`define BLDR_CFG_DDR 4
`define BLDR_CFG_ASYNC 5
`define BLDR_CFG_START_LSB 8
`define BLDR_CFG_START_MSB 15
// ----------------------------------------
// Reset config and addresses
// ----------------------------------------
`define BLDR_RCFG_NO_PRE 4
`define BLDR_RCFG_NO_LOAD 5
`define BLDR_RCFG_WAKE 6
`define BLDR_HDR_BYTES 5'h10
`define BLDR_HDR_WORDS 2'h3
`define BLDR_CALL_ADDR 32'hFFA00000
`define BLDR_FIFO_WORDS 5'h10
`define BLDR_FLAG_LAST 0
`define BLDR_FLAG_CALL 1
`endif

/* logic/bldr_pkg.sv */
package bldr_pkg;
    // Host port width and handshake style
    typedef struct packed {
        logic wide16;
        logic ack_style;
        logic little_endian;
    } bldr_port_cfg_t;
    // Decoded block header
    typedef struct packed {
        logic [31:0] dest;
        logic [31:0] count;
        logic [31:0] flags;
    } bldr_hdr_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PRE_CFG, ST_PRE_SETUP, ST_HDR, ST_DATA, ST_CALL, ST_CALL_WAIT,
        ST_JUMP, ST_DONE, ST_FAIL
    } bldr_state_t;
endpackage

/* logic/bldr_core.sv */
`timescale 1ns/1ps
`include "bldr_defs.svh"
module bldr_core (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] boot_select_pins,
    input wire logic soft_reset,
    input wire logic hib_wakeup,
    input wire logic [2:0] system_reset_config,
    input wire logic [31:0] reset_vector_register,
    output logic [7:0] otp_addr,
    output logic otp_rd,
    input wire logic [31:0] otp_rdata,
    input wire logic otp_rvalid,
    input wire logic host_wr,
    input wire logic [31:0] host_wdata,
    input wire logic host_interrupt_command,
    output logic host_cfg_ok,
    output logic host_ready,
    output logic host_ack,
    output logic host_wait_line,
    output bldr_pkg::bldr_port_cfg_t port_cfg,
    output logic [3:0] setup_req,
    output logic mem_wr,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic call_req,
    input wire logic call_ret,
    output logic exec_start,
    output logic [31:0] exec_addr,
    output logic boot_fail,
    output logic fast_path
);
    bldr_pkg::bldr_state_t state_q;
    logic [3:0] sel_q;
    logic armed_q;
    logic [31:0] cfg_q;
    logic [7:0] page_q;
    logic [11:0] otp_bytes_q;
    logic [1:0] hdr_idx_q;
    bldr_pkg::bldr_hdr_t hdr_q;
    logic [4:0] fifo_cnt_q;
    logic skip_pre_q;
    logic skip_load_q;
    logic rd_pend_q;
    logic [1:0] rd_word_q;

    // ----------------------------------------
    // Word source
    // ----------------------------------------
    function automatic logic is_host(input logic [3:0] s);
        is_host = (s == `BLDR_SEL_HOST16) || (s == `BLDR_SEL_HOST8);
    endfunction

    logic src_host;
    logic word_v;
    logic [31:0] word;
    assign src_host = is_host(sel_q);
    // Host port and one-time memory share the loader path
    assign word_v = src_host ? host_wr : otp_rvalid;
    assign word = src_host ? host_wdata : otp_rdata;

    // ----------------------------------------
    // Boot select capture
    // ----------------------------------------
    // Caught one clock after release; a reset value of a pin is not allowed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 4'h0;
            armed_q <= 1'b0;
            skip_pre_q <= 1'b0;
            skip_load_q <= 1'b0;
            fast_path <= 1'b0;
        end else if (!armed_q) begin
            armed_q <= 1'b1;
            sel_q <= boot_select_pins;
            skip_pre_q <= soft_reset && system_reset_config[`BLDR_RCFG_NO_PRE - 4];
            skip_load_q <= soft_reset && system_reset_config[`BLDR_RCFG_NO_LOAD - 4];
            // Wakeup skips the one-time readout for speed
            fast_path <= hib_wakeup ||
                (soft_reset && system_reset_config[`BLDR_RCFG_WAKE - 4]);
        end
    end

    // ----------------------------------------
    // Host port setup
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            port_cfg <= '0;
        end else begin
            port_cfg.wide16 <= (sel_q == `BLDR_SEL_HOST16);
            port_cfg.ack_style <= (sel_q == `BLDR_SEL_HOST16);
            port_cfg.little_endian <= src_host;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= bldr_pkg::ST_IDLE;
            cfg_q <= 32'h0;
            page_q <= `BLDR_OTP_START_DEF;
            hdr_idx_q <= 2'h0;
            hdr_q <= '0;
            setup_req <= 4'h0;
            mem_wr <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            call_req <= 1'b0;
            exec_start <= 1'b0;
            exec_addr <= 32'h0;
            boot_fail <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            exec_start <= 1'b0;
            setup_req <= 4'h0;
            case (state_q)
                bldr_pkg::ST_IDLE: begin
                    if (armed_q) begin
                        if (skip_load_q) begin
                            state_q <= bldr_pkg::ST_JUMP;
                        end else if (skip_pre_q || fast_path) begin
                            state_q <= bldr_pkg::ST_HDR;
                        end else begin
                            state_q <= bldr_pkg::ST_PRE_CFG;
                        end
                    end
                end
                bldr_pkg::ST_PRE_CFG: begin
                    // Drain the whole page so no config word leaks into the header
                    if (otp_rvalid) begin
                        if (rd_word_q == 2'h0) begin
                            cfg_q <= otp_rdata;
                        end
                        if (rd_word_q == `BLDR_PAGE_LAST_WORD) begin
                            state_q <= bldr_pkg::ST_PRE_SETUP;
                        end
                    end
                end
                bldr_pkg::ST_PRE_SETUP: begin
                    setup_req <= {cfg_q[`BLDR_CFG_ASYNC], cfg_q[`BLDR_CFG_DDR],
                        cfg_q[`BLDR_CFG_VREG], cfg_q[`BLDR_CFG_PLL]};
                    if (cfg_q[`BLDR_CFG_START_MSB:`BLDR_CFG_START_LSB] != 8'h00) begin
                        page_q <= cfg_q[`BLDR_CFG_START_MSB:`BLDR_CFG_START_LSB];
                    end
                    if ((sel_q == `BLDR_SEL_OTP && cfg_q[`BLDR_CFG_OTP_DIS]) ||
                        (src_host && cfg_q[`BLDR_CFG_HOST_DIS])) begin
                        state_q <= bldr_pkg::ST_FAIL;
                    end else begin
                        state_q <= bldr_pkg::ST_HDR;
                    end
                end
                bldr_pkg::ST_HDR: begin
                    if (src_host && host_interrupt_command) begin
                        state_q <= bldr_pkg::ST_CALL;
                    end else if (word_v) begin
                        hdr_idx_q <= hdr_idx_q + 2'h1;
                        case (hdr_idx_q)
                            2'h0: hdr_q.dest <= word;
                            2'h1: hdr_q.count <= word;
                            2'h2: hdr_q.flags <= word;
                            default: begin
                                hdr_idx_q <= 2'h0;
                                state_q <= (hdr_q.flags[`BLDR_FLAG_CALL]) ?
                                    bldr_pkg::ST_CALL : bldr_pkg::ST_DATA;
                            end
                        endcase
                    end
                end
                bldr_pkg::ST_DATA: begin
                    if (hdr_q.count == 32'h0) begin
                        // Last flag ends the stream, else next header
                        state_q <= hdr_q.flags[`BLDR_FLAG_LAST] ?
                            bldr_pkg::ST_JUMP : bldr_pkg::ST_HDR;
                    end else if (word_v) begin
                        mem_wr <= 1'b1;
                        mem_addr <= hdr_q.dest;
                        mem_wdata <= word;
                        hdr_q.dest <= hdr_q.dest + 32'h4;
                        hdr_q.count <= (hdr_q.count > 32'h4) ? hdr_q.count - 32'h4 : 32'h0;
                    end
                end
                bldr_pkg::ST_CALL: begin
                    call_req <= 1'b1;
                    exec_addr <= `BLDR_CALL_ADDR;
                    state_q <= bldr_pkg::ST_CALL_WAIT;
                end
                bldr_pkg::ST_CALL_WAIT: begin
                    // Callee may never return; loader just waits
                    if (call_ret) begin
                        call_req <= 1'b0;
                        hdr_idx_q <= 2'h0;
                        hdr_q.flags <= 32'h0;
                        state_q <= bldr_pkg::ST_HDR;
                    end
                end
                bldr_pkg::ST_JUMP: begin
                    exec_start <= 1'b1;
                    exec_addr <= reset_vector_register;
                    state_q <= bldr_pkg::ST_DONE;
                end
                bldr_pkg::ST_DONE: begin
                    state_q <= bldr_pkg::ST_DONE;
                end
                bldr_pkg::ST_FAIL: begin
                    boot_fail <= 1'b1;
                end
                default: begin
                    state_q <= bldr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // One-time memory read pointer
    // ----------------------------------------
    // One read in flight at a time; page_q counts 16-byte pages
    logic otp_need;
    assign otp_need = (state_q == bldr_pkg::ST_PRE_CFG) ||
        (sel_q == `BLDR_SEL_OTP &&
         (state_q == bldr_pkg::ST_HDR || state_q == bldr_pkg::ST_DATA));
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            otp_rd <= 1'b0;
            otp_addr <= 8'h00;
            rd_pend_q <= 1'b0;
            rd_word_q <= 2'h0;
            otp_bytes_q <= 12'h000;
        end else begin
            otp_rd <= 1'b0;
            // A page streams four words; the read stays open until the last
            if (otp_rvalid) begin
                rd_word_q <= rd_word_q + 2'h1;
                if (rd_word_q == `BLDR_PAGE_LAST_WORD) begin
                    rd_pend_q <= 1'b0;
                end
            end else if (otp_need && !rd_pend_q && !otp_rd) begin
                rd_word_q <= 2'h0;
                if (state_q == bldr_pkg::ST_PRE_CFG) begin
                    otp_addr <= `BLDR_OTP_CFG_ADDR;
                    otp_rd <= 1'b1;
                    rd_pend_q <= 1'b1;
                end else if (otp_bytes_q < `BLDR_OTP_MAX_BYTES &&
                             (page_q + otp_bytes_q[11:4]) <= `BLDR_OTP_LAST_PAGE) begin
                    otp_addr <= page_q + otp_bytes_q[11:4];
                    otp_rd <= 1'b1;
                    rd_pend_q <= 1'b1;
                    otp_bytes_q <= otp_bytes_q + `BLDR_OTP_PAGE_BYTES;
                end
            end
        end
    end

    // ----------------------------------------
    // Host handshake and wait line
    // ----------------------------------------
    logic loading;
    assign loading = (state_q == bldr_pkg::ST_HDR) || (state_q == bldr_pkg::ST_DATA);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            host_cfg_ok <= 1'b0;
            host_ready <= 1'b0;
            host_ack <= 1'b0;
            host_wait_line <= 1'b0;
            fifo_cnt_q <= 5'h00;
        end else begin
            host_cfg_ok <= src_host && state_q == bldr_pkg::ST_HDR;
            host_ready <= (sel_q == `BLDR_SEL_HOST16) && loading;
            // Wait line held still in NAND boot
            host_wait_line <= (sel_q != `BLDR_SEL_NAND) && loading;
            host_ack <= 1'b0;
            if (sel_q == `BLDR_SEL_HOST8 && loading) begin
                if (state_q == bldr_pkg::ST_HDR && hdr_idx_q == 2'h0 && fifo_cnt_q == 5'h00) begin
                    host_ack <= 1'b1;
                    fifo_cnt_q <= `BLDR_FIFO_WORDS;
                end else if (host_wr && fifo_cnt_q != 5'h00) begin
                    if (fifo_cnt_q == 5'h01) begin
                        host_ack <= 1'b1;
                        fifo_cnt_q <= `BLDR_FIFO_WORDS;
                    end else begin
                        fifo_cnt_q <= fifo_cnt_q - 5'h01;
                    end
                end
            end
        end
    end
endmodule

/* sim/bldr_checker_assertions.sv */
`timescale 1ns/1ps
module bldr_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] boot_select_pins,
    input wire logic [31:0] reset_vector_register,
    input wire logic otp_rd,
    input wire logic host_ready,
    input wire logic host_ack,
    input wire logic host_wait_line,
    input wire bldr_pkg::bldr_port_cfg_t port_cfg,
    input wire logic [3:0] setup_req,
    input wire logic call_req,
    input wire logic call_ret,
    input wire logic exec_start,
    input wire logic [31:0] exec_addr,
    input wire logic boot_fail,
    input wire logic fast_path
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_call_open;
        call_req && !call_ret;
    endsequence
    sequence s_port_set;
        port_cfg != 3'h0;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_ACK_PULSE: assert property (host_ack |=> !host_ack)
        else $error("host ack longer than one cycle");
    AST_ACK_MODE8: assert property (host_ack |-> port_cfg == 3'h1)
        else $error("host ack outside narrow interrupt mode");
    AST_READY_MODE16: assert property (host_ready |-> port_cfg == 3'h7)
        else $error("host ready outside wide ack mode");
    AST_CALL_HOLD: assert property (s_call_open |=> call_req)
        else $error("call request dropped before return");
    AST_EXEC_VEC: assert property (exec_start |-> exec_addr == reset_vector_register)
        else $error("execution address differs from reset vector");
    AST_NAND_QUIET: assert property (boot_select_pins == 4'hD |-> !host_wait_line)
        else $error("wait line moved in nand mode");
    AST_SETUP_PULSE: assert property (setup_req != 4'h0 |=> setup_req == 4'h0)
        else $error("setup request longer than one cycle");
    AST_FAIL_STICKY: assert property (boot_fail |=> boot_fail)
        else $error("boot fail flag cleared");
    AST_FAST_NO_OTP: assert property (fast_path && boot_select_pins != 4'hB |-> !otp_rd)
        else $error("fast path still reads one-time memory");
    AST_PORT_FIXED: assert property (s_port_set |=> $stable(port_cfg))
        else $error("port setup changed after capture");
endmodule

bind bldr_core bldr_checker chk (.ref_clk, .rstn, .boot_select_pins, .reset_vector_register,
    .otp_rd, .host_ready, .host_ack, .host_wait_line, .port_cfg, .setup_req, .call_req,
    .call_ret, .exec_start, .exec_addr, .boot_fail, .fast_path);

/* sim/bldr_host_model.sv */
`timescale 1ns/1ps
module bldr_host_model (
    input wire logic ref_clk,
    input wire logic host_cfg_ok,
    input wire logic host_ready,
    output logic host_wr,
    output logic [31:0] host_wdata,
    output logic host_interrupt_command
);
    initial begin
        host_wr = 1'b0;
        host_wdata = 32'h0;
        host_interrupt_command = 1'b0;
    end
    // One word per edge; strobe stays up between back-to-back words
    task automatic put(input logic [31:0] w);
        host_wr <= 1'b1;
        host_wdata <= w;
        @(posedge ref_clk);
    endtask
    // Interrupt command pulse, only while config is permitted
    task automatic irq();
        while (host_cfg_ok !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        host_interrupt_command <= 1'b1;
        @(posedge ref_clk);
        host_interrupt_command <= 1'b0;
    endtask
    // Host writes one block: a four-word header, then the data words
    task automatic block(input logic [31:0] dst, input logic [31:0] cnt, input logic [31:0] flg,
                         input logic wide);
        int n;
        for (n = 0; n < 400 && host_cfg_ok !== 1'b1; n++) @(negedge ref_clk);
        @(posedge ref_clk);
        put(dst);
        put(cnt);
        put(flg);
        put(32'h0);
        if (wide) begin
            host_wr <= 1'b0;
            for (n = 0; n < 400 && host_ready !== 1'b1; n++) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        for (n = 0; n < (cnt + 3) / 4; n++) put(32'hA5000000 + n);
        // Idle bus shows the inverse, never a stale word
        host_wr <= 1'b0;
        host_wdata <= ~host_wdata;
    endtask
endmodule

/* sim/boot_loader_otp_host_port_tb.sv */
`timescale 1ns/1ps
module boot_loader_otp_host_port_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] boot_select_pins = 4'hE;
    logic soft_reset = 1'b0;
    logic hib_wakeup = 1'b0;
    logic [2:0] system_reset_config = 3'h0;
    logic [31:0] reset_vector_register = 32'h00001234;
    logic [31:0] otp_rdata = 32'h0;
    logic otp_rvalid = 1'b0;
    logic call_ret = 1'b0;
    logic [31:0] cfg = 32'h0;
    logic host_wr, host_interrupt_command, otp_rd, host_cfg_ok, host_ready, host_ack;
    logic host_wait_line, mem_wr, call_req, exec_start, boot_fail, fast_path;
    logic [31:0] host_wdata, mem_addr, mem_wdata, exec_addr;
    logic [7:0] otp_addr, pg;
    logic [3:0] setup_req, setup_seen;
    bldr_pkg::bldr_port_cfg_t port_cfg;
    logic [63:0] memq [$];
    int bad_count = 0;
    int tests_run = 0;
    int otp_cnt, ack_cnt;
    int k = 4;
    always #12.5 ref_clk = ~ref_clk;
    bldr_core dut (.ref_clk, .rstn, .boot_select_pins, .soft_reset, .hib_wakeup,
        .system_reset_config, .reset_vector_register, .otp_addr, .otp_rd, .otp_rdata,
        .otp_rvalid, .host_wr, .host_wdata, .host_interrupt_command, .host_cfg_ok, .host_ready,
        .host_ack, .host_wait_line, .port_cfg, .setup_req, .mem_wr, .mem_addr, .mem_wdata,
        .call_req, .call_ret, .exec_start, .exec_addr, .boot_fail, .fast_path);
    bldr_host_model host (.ref_clk, .host_cfg_ok, .host_ready, .host_wr, .host_wdata,
        .host_interrupt_command);
    // One-time memory: page 0 is config, stream starts at the chosen page
    function automatic logic [31:0] otp_word(input logic [7:0] p, input int j);
        int off;
        off = (p - (cfg[15:8] == 8'h0 ? 8'h40 : cfg[15:8])) * 4 + j;
        if (p == 8'h0) return cfg;
        case (off)
            0: return 32'h00002000;
            1: return 32'h00000004;
            2: return 32'h00000001;
            4: return 32'hC0DE0001;
            default: return 32'h0;
        endcase
    endfunction
    always @(posedge ref_clk) begin
        otp_rvalid <= 1'b0;
        otp_rdata <= ~otp_rdata; // Nothing stale between words
        if (otp_rd === 1'b1) begin
            pg <= otp_addr;
            k <= 0;
        end else if (k < 4) begin
            otp_rvalid <= 1'b1;
            otp_rdata <= otp_word(pg, k);
            k <= k + 1;
        end
    end
    // Settled samples of pulses
    always @(negedge ref_clk) begin
        if (mem_wr === 1'b1) memq.push_back({mem_addr, mem_wdata});
        if (otp_rd === 1'b1) otp_cnt++;
        if (host_ack === 1'b1) ack_cnt++;
        setup_seen |= setup_req;
    end
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic boot(input logic [3:0] p, input logic s, input logic h, input logic [2:0] r);
        @(posedge ref_clk);
        rstn <= 1'b0;
        boot_select_pins <= p;
        soft_reset <= s;
        hib_wakeup <= h;
        system_reset_config <= r;
        repeat (4) @(posedge ref_clk);
        memq.delete();
        otp_cnt = 0;
        ack_cnt = 0;
        setup_seen = 4'h0;
        rstn <= 1'b1;
    endtask
    task automatic wt(input int s);
        logic [3:0] v;
        for (int n = 0; n < 400; n++) begin
            @(negedge ref_clk);
            v = {exec_start, call_req, host_cfg_ok, boot_fail};
            if (v[s] === 1'b1) break;
        end
    endtask
    task automatic t_otp(input logic [7:0] st);
        cfg = {16'h0, st, 8'h0};
        boot(4'hB, 1'b0, 1'b0, 3'h0);
        for (int n = 0; n < 200 && !(otp_rd === 1'b1 && otp_addr != 8'h0); n++) @(negedge ref_clk);
        chk("stream page", otp_addr, st == 8'h0 ? 8'h40 : st);
        wt(3);
        chk("block write", memq.size() > 0 ? memq[0] : 64'h0, 64'h00002000C0DE0001);
        chk("exec addr", exec_addr, reset_vector_register);
        $display("otp boot from page %h done", st);
    endtask
    task automatic t_host16();
        logic [63:0] e [3] = '{64'h00000100A5000000, 64'h00000104A5000001, 64'h00000200A5000000};
        cfg = 32'h0;
        boot(4'hE, 1'b0, 1'b0, 3'h0);
        wt(1);
        chk("wide cfg", port_cfg, 3'h7);
        chk("wait line", host_wait_line, 1'b1);
        @(posedge ref_clk);
        boot_select_pins <= 4'hF;
        host.irq();
        wt(2);
        chk("call req", call_req, 1'b1);
        chk("call addr", exec_addr, 32'hFFA00000);
        @(posedge ref_clk);
        call_ret <= 1'b1;
        @(posedge ref_clk);
        call_ret <= 1'b0;
        host.block(32'h100, 32'h8, 32'h0, 1'b1);
        host.block(32'h200, 32'h4, 32'h1, 1'b1);
        wt(3);
        chk("exec addr", exec_addr, reset_vector_register);
        chk("cfg held", port_cfg, 3'h7);
        for (int i = 0; i < 3; i++) chk("host write", memq.size() > i ? memq[i] : 64'h0, e[i]);
        $display("wide host boot done");
    endtask
    task automatic t_host8();
        boot(4'hF, 1'b0, 1'b0, 3'h0);
        wt(1);
        chk("narrow cfg", port_cfg, 3'h1);
        host.block(32'h300, 32'h40, 32'h1, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk("ack count", ack_cnt, 2);
        $display("narrow host boot done");
    endtask
    task automatic t_misc();
        // Bit 5 wakeup, bit 4 expected fast path, bit 3 soft reset, bits 2:0 reset config
        logic [5:0] tb [4] = '{6'h30, 6'h1C, 6'h08, 6'h00};
        for (int i = 0; i < 4; i++) begin
            boot(4'hE, tb[i][3], tb[i][5], tb[i][2:0]);
            wt(1);
            chk("fast path", fast_path, tb[i][4]);
            chk("otp skipped", otp_cnt == 0, tb[i][4]);
        end
        boot(4'hE, 1'b1, 1'b0, 3'h2);
        wt(3);
        chk("skip loader", exec_addr, reset_vector_register);
        chk("skip loader otp", otp_cnt, 0);
        cfg = 32'h3C;
        boot(4'hE, 1'b0, 1'b0, 3'h0);
        wt(1);
        chk("setup", setup_seen, 4'hF);
        cfg = 32'h2;
        boot(4'hE, 1'b0, 1'b0, 3'h0);
        wt(0);
        chk("disabled", boot_fail, 1'b1);
        boot(4'hD, 1'b0, 1'b0, 3'h0);
        repeat (60) @(negedge ref_clk);
        chk("nand wait", host_wait_line, 1'b0);
        $display("reset kinds and setup done");
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        t_otp(8'h0);
        t_otp(8'h30);
        t_host16();
        t_host8();
        t_misc();
        results();
    end
    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        results();
    end
endmodule
